// ---- hdl/uim_regs.svh ----
// Purpose: register indices, field positions and reset values of the interrupt block
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef UIM_REGS_SVH
`define UIM_REGS_SVH

// register indices (byte address = index * 4)
`define UIM_IDX_CHAN_CMD 4'h2
`define UIM_IDX_FLAGS 4'h4
`define UIM_IDX_STATUS 4'h5
`define UIM_IDX_START_CT 4'he
`define UIM_IDX_STOP_CT 4'hf

// address field positions
`define UIM_ADDR_IDX_HI 5
`define UIM_ADDR_IDX_LO 2

// status bit positions
`define UIM_ST_TX_A 0
`define UIM_ST_RX_A 1
`define UIM_ST_BRK_A 2
`define UIM_ST_CT_RDY 3
`define UIM_ST_TX_B 4
`define UIM_ST_RX_B 5
`define UIM_ST_BRK_B 6
`define UIM_ST_IN_CHG 7

// aux control fields
`define UIM_AUX_TIMER_BIT 6

// channel command fields
`define UIM_CMD_RST_BRK_A 0
`define UIM_CMD_RST_BRK_B 1

// reset values
`define UIM_RST_BYTE 8'h00
`define UIM_RST_NIB 4'h0
`define UIM_RST_WORD 32'h0000_0000

`endif

// ---- hdl/uim_pkg.sv ----
// Purpose: shared types of the interrupt block
// Assumes: nothing
// Notes: constants live in uim_regs.svh
package uim_pkg;

  typedef logic [3:0] uim_idx_type; // register index
  typedef logic [7:0] uim_byte_type; // one register byte
  typedef logic [3:0] uim_nib_type; // four input pins

endpackage : uim_pkg

// ---- hdl/uim_sticky_bit.sv ----
// Purpose: one sticky flag, set by hardware, cleared by a command
// Assumes: set and clear are one-cycle strobes or levels
// Notes: a set in the clearing cycle wins
module uim_sticky_bit (
  input wire logic ref_clk, // block clock
  input wire logic rst_n, // async reset, active low
  input wire logic set_i, // set request
  input wire logic clr_i, // clear request
  output logic flag_r // flag state
);

  // set beats clear so no event is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end

endmodule : uim_sticky_bit

// ---- hdl/uim_irq_top.sv ----
// Purpose: input change flags, interrupt status, mask and irq output behind APB
// Assumes: all inputs synchronous to ref_clk; 10 MHz clock
// Notes: read side effects and read data are taken in the APB setup cycle
// How it works
// - pin change sets its upper-nibble flag
// - flags register read clears all flags
// - flags read also clears input change status
// - lower nibble shows live pin levels
// - irq low when status and mask both set
// - status read ignores mask
// - status bits reset to zero
// - status bit layout fixed, 1 is active
// - input change status needs aux enable
// - break status sticky until reset-break command
// - receiver status follows fill or watchdog
// - transmitter status follows level, not ready
// - counter mode: terminal count sets, stop clears
// - timer mode: every second zero sets
// - mask gates only the irq output
// - aux low bits enable pin propagation
`include "uim_regs.svh"

module uim_irq_top (
  input wire logic ref_clk, // block clock, 10 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  input wire logic in_pin_0, // input pin 0
  input wire logic in_pin_1, // input pin 1
  input wire logic in_pin_2, // input pin 2
  input wire logic in_pin_3, // input pin 3
  input wire logic brk_evt_chan_a, // break start/end pulse, chan a
  input wire logic brk_evt_chan_b, // break start/end pulse, chan b
  input wire logic rx_irq_chan_a, // receiver interrupt level, chan a
  input wire logic rx_irq_chan_b, // receiver interrupt level, chan b
  input wire logic tx_irq_chan_a, // transmitter interrupt level, chan a
  input wire logic tx_irq_chan_b, // transmitter interrupt level, chan b
  input wire logic ct_zero, // counter/timer reached zero, pulse
  output logic irq_out_n, // interrupt output, active low
  output logic [7:0] status_raw // unmasked status for output pins
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  uim_pkg::uim_nib_type pins; // gathered input pins
  uim_pkg::uim_nib_type pins_prev_r; // pins one cycle ago
  logic pins_valid_r; // previous sample is meaningful
  uim_pkg::uim_nib_type pin_chg; // qualified change this cycle
  uim_pkg::uim_nib_type chg_flag; // sticky change flags
  uim_pkg::uim_byte_type aux_control_r; // aux control register
  uim_pkg::uim_byte_type interrupt_mask_r; // mask register
  uim_pkg::uim_byte_type interrupt_status; // assembled status
  logic rx_a_r; // registered receiver level a
  logic rx_b_r; // registered receiver level b
  logic tx_a_r; // registered transmitter level a
  logic tx_b_r; // registered transmitter level b
  logic in_chg_st; // input change status bit
  logic brk_a_st; // break a status bit
  logic brk_b_st; // break b status bit
  logic ct_rdy_st; // counter ready status bit
  logic zero_half_r; // timer: odd zero seen
  logic ct_set; // counter ready set strobe
  logic irq_n_r; // registered irq output
  logic [31:0] prdata_r; // registered read data
  logic pslverr_r; // registered error
  uim_pkg::uim_idx_type idx; // decoded register index
  logic addr_ok; // aligned and in range
  logic setup_rd; // read setup cycle
  logic setup_wr; // write setup cycle
  logic wr_take; // write takes effect
  logic rd_flags; // flags register read
  logic rd_status; // status register read
  logic rd_start; // start counter command
  logic rd_stop; // stop counter command
  logic wr_aux; // aux control write
  logic wr_mask; // mask write
  logic wr_cmd; // channel command write
  logic mapped; // access hits a register

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign idx = paddr[`UIM_ADDR_IDX_HI:`UIM_ADDR_IDX_LO];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
  assign setup_rd = psel && !penable && !pwrite;
  assign setup_wr = psel && !penable && pwrite;
  // writes land at the completing access edge, low byte lane only
  assign wr_take = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_flags = setup_rd && addr_ok && (idx == `UIM_IDX_FLAGS);
  assign rd_status = setup_rd && addr_ok && (idx == `UIM_IDX_STATUS);
  assign rd_start = setup_rd && addr_ok && (idx == `UIM_IDX_START_CT);
  assign rd_stop = setup_rd && addr_ok && (idx == `UIM_IDX_STOP_CT);
  assign wr_aux = wr_take && (idx == `UIM_IDX_FLAGS);
  assign wr_mask = wr_take && (idx == `UIM_IDX_STATUS);
  assign wr_cmd = wr_take && (idx == `UIM_IDX_CHAN_CMD);

  // which accesses are legal, per direction
  always_comb begin
    mapped = 1'b0;
    if (addr_ok) begin
      if (pwrite) begin
        mapped = (idx == `UIM_IDX_FLAGS) || (idx == `UIM_IDX_STATUS) ||
          (idx == `UIM_IDX_CHAN_CMD);
      end else begin
        mapped = (idx == `UIM_IDX_FLAGS) || (idx == `UIM_IDX_STATUS) ||
          (idx == `UIM_IDX_START_CT) || (idx == `UIM_IDX_STOP_CT);
      end
    end
  end

  // zero wait states
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data and error, captured in the setup cycle

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= `UIM_RST_WORD;
    end else if (setup_rd) begin
      if (rd_flags) begin
        prdata_r <= {24'h00_0000, chg_flag, pins};
      end else if (rd_status) begin
        prdata_r <= {24'h00_0000, interrupt_status};
      end else begin
        prdata_r <= `UIM_RST_WORD; // commands and unmapped read zero
      end
    end
  end

  // error on any unmapped or misaligned access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_r <= 1'b0;
    end else if (setup_rd || setup_wr) begin
      pslverr_r <= !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written registers

  // aux control, low nibble enables pin propagation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_control_r <= `UIM_RST_BYTE;
    end else if (wr_aux) begin
      aux_control_r <= pwdata[7:0];
    end
  end

  // mask, same layout as status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_mask_r <= `UIM_RST_BYTE;
    end else if (wr_mask) begin
      interrupt_mask_r <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input pin change detection

  assign pins = {in_pin_3, in_pin_2, in_pin_1, in_pin_0};

  // previous sample; first cycle after reset only loads
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_r <= `UIM_RST_NIB;
      pins_valid_r <= 1'b0;
    end else begin
      pins_prev_r <= pins;
      pins_valid_r <= 1'b1;
    end
  end

  assign pin_chg = pins_valid_r ? (pins ^ pins_prev_r) : `UIM_RST_NIB;

  // one sticky flag per pin, cleared by a flags read
  for (genvar gi = 0; gi < 4; gi++) begin : g_chg
    uim_sticky_bit u_flag (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .set_i(pin_chg[gi]),
      .clr_i(rd_flags),
      .flag_r(chg_flag[gi])
    );
  end

  // input change status: enabled changes only
  uim_sticky_bit u_in_chg (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(|(pin_chg & aux_control_r[3:0])),
    .clr_i(rd_flags),
    .flag_r(in_chg_st)
  );

  ////////////////////////////////////////////////////////////////////////////
  // break change status, cleared by channel commands

  uim_sticky_bit u_brk_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(brk_evt_chan_a),
    .clr_i(wr_cmd && pwdata[`UIM_CMD_RST_BRK_A]),
    .flag_r(brk_a_st)
  );

  uim_sticky_bit u_brk_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(brk_evt_chan_b),
    .clr_i(wr_cmd && pwdata[`UIM_CMD_RST_BRK_B]),
    .flag_r(brk_b_st)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter ready

  // timer mode: track odd/even zero counts; start restarts the cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_half_r <= 1'b0;
    end else if (rd_start) begin
      zero_half_r <= 1'b0;
    end else if (ct_zero && aux_control_r[`UIM_AUX_TIMER_BIT]) begin
      zero_half_r <= !zero_half_r;
    end
  end

  // counter mode sets on every terminal count, timer on every second zero
  assign ct_set = ct_zero && (!aux_control_r[`UIM_AUX_TIMER_BIT] || zero_half_r);

  uim_sticky_bit u_ct_rdy (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(ct_set),
    .clr_i(rd_stop),
    .flag_r(ct_rdy_st)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receiver and transmitter levels

  // channel levels are registered, not latched
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_a_r <= 1'b0;
      rx_b_r <= 1'b0;
      tx_a_r <= 1'b0;
      tx_b_r <= 1'b0;
    end else begin
      rx_a_r <= rx_irq_chan_a;
      rx_b_r <= rx_irq_chan_b;
      tx_a_r <= tx_irq_chan_a;
      tx_b_r <= tx_irq_chan_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status assembly and irq

  // every source is a flop reset to zero
  always_comb begin
    interrupt_status = `UIM_RST_BYTE;
    interrupt_status[`UIM_ST_IN_CHG] = in_chg_st;
    interrupt_status[`UIM_ST_BRK_B] = brk_b_st;
    interrupt_status[`UIM_ST_RX_B] = rx_b_r;
    interrupt_status[`UIM_ST_TX_B] = tx_b_r;
    interrupt_status[`UIM_ST_CT_RDY] = ct_rdy_st;
    interrupt_status[`UIM_ST_BRK_A] = brk_a_st;
    interrupt_status[`UIM_ST_RX_A] = rx_a_r;
    interrupt_status[`UIM_ST_TX_A] = tx_a_r;
  end

  // unmasked copy for output port routing
  assign status_raw = interrupt_status;

  // irq low one cycle after any enabled source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= !(|(interrupt_status & interrupt_mask_r));
    end
  end

  assign irq_out_n = irq_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_chg_sets_flag;
    @(posedge ref_clk) disable iff (!rst_n)
      pin_chg[0] |=> chg_flag[0];
  endproperty
  a_chg_sets_flag: assert property (p_chg_sets_flag) else $error("pin change not flagged");

  property p_read_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_flags && !pin_chg[1]) |=> !chg_flag[1];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag survived read");

  property p_read_clears_st;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_flags && !(|(pin_chg & aux_control_r[3:0]))) |=> !in_chg_st;
  endproperty
  a_read_clears_st: assert property (p_read_clears_st) else $error("status bit 7 kept");

  property p_live_pins;
    @(posedge ref_clk) disable iff (!rst_n)
      rd_flags |=> (prdata[3:0] == $past(pins));
  endproperty
  a_live_pins: assert property (p_live_pins) else $error("live pins wrong");

  property p_irq_level;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> (irq_out_n == !(|($past(interrupt_status) & $past(interrupt_mask_r))));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_status_unmasked;
    @(posedge ref_clk) disable iff (!rst_n)
      rd_status |=> (prdata[7:0] == $past(interrupt_status));
  endproperty
  a_status_unmasked: assert property (p_status_unmasked) else $error("status masked");

  property p_disabled_no_status;
    @(posedge ref_clk) disable iff (!rst_n)
      (!in_chg_st && !(|(pin_chg & aux_control_r[3:0]))) |=> !in_chg_st;
  endproperty
  a_disabled_no_status: assert property (p_disabled_no_status) else $error("bit 7 unqualified");

  property p_break_holds;
    @(posedge ref_clk) disable iff (!rst_n)
      (brk_a_st && !(wr_cmd && pwdata[`UIM_CMD_RST_BRK_A])) |=> brk_a_st;
  endproperty
  a_break_holds: assert property (p_break_holds) else $error("break bit dropped");

  property p_timer_second_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (ct_zero && aux_control_r[`UIM_AUX_TIMER_BIT] && !zero_half_r && !ct_rdy_st && !rd_start)
        |=> !ct_rdy_st;
  endproperty
  a_timer_second_zero: assert property (p_timer_second_zero) else $error("odd zero set");

  property p_stop_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_stop && !ct_set) |=> !ct_rdy_st;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop kept ready");

  c_irq_fires: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(irq_out_n));
  c_flags_read: cover property (@(posedge ref_clk) disable iff (!rst_n) rd_flags && |chg_flag);
  c_race: cover property (@(posedge ref_clk) disable iff (!rst_n) rd_flags && |pin_chg);
  c_stop: cover property (@(posedge ref_clk) disable iff (!rst_n) rd_stop && ct_rdy_st);

endmodule : uim_irq_top

// ---- testbench/uim_host_model.sv ----
// Purpose: host cpu model, apb master of the interrupt block
// Assumes: xfer is entered just after a rising edge
// Notes: waits for pready, no fixed wait count
module uim_host_model (
  input wire logic ref_clk, // block clock
  output logic psel, // apb select
  output logic penable, // apb access phase
  output logic pwrite, // apb direction
  output logic [7:0] paddr, // apb byte address
  output logic [31:0] pwdata, // apb write data
  output logic [3:0] pstrb, // apb byte strobes
  input wire logic pready, // apb ready
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr // apb error
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  // setup, access until pready, then release; mask uses status layout
  task xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    pstrb <= 4'h1;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    // released address and write data show inverted value, never stale data
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~adr;
    pwdata <= ~wd;
    @(posedge ref_clk);
  endtask : xfer
endmodule : uim_host_model

// ---- testbench/uim_irq_top_test.sv ----
// Purpose: self-checking bench of the interrupt block
// Assumes: 10 MHz clock, zero wait apb slave
// Notes: scenarios start just after a rising edge
module uim_irq_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_FLG = 8'h10; // flags / aux control
  localparam logic [7:0] A_ST = 8'h14; // status / mask
  localparam logic [7:0] A_CMD = 8'h08; // channel command
  localparam logic [7:0] A_GO = 8'h38; // start counter
  localparam logic [7:0] A_STOP = 8'h3c; // stop counter, index fifteen
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_out_n, rerr;
  logic [7:0] paddr, status_raw;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, pins, lv; // lv: rx_b tx_b rx_a tx_a
  logic [1:0] brk; // break pulses b,a
  logic ct_zero;
  int err_count, compares;
  ////////////////////////////////////////////////////////////////////////
  uim_host_model i_host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  uim_irq_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .in_pin_0(pins[0]), .in_pin_1(pins[1]), .in_pin_2(pins[2]),
    .in_pin_3(pins[3]), .brk_evt_chan_a(brk[0]), .brk_evt_chan_b(brk[1]),
    .rx_irq_chan_a(lv[1]), .rx_irq_chan_b(lv[3]), .tx_irq_chan_a(lv[0]),
    .tx_irq_chan_b(lv[2]), .ct_zero(ct_zero), .irq_out_n(irq_out_n),
    .status_raw(status_raw));
  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  always #50 ref_clk = ~ref_clk;
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, {24'h000000, d}, rdat, rerr);
  endtask : wr
  task end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  // pin changes, live levels, enable gating, read clears
  task t_pins();
    wr(A_FLG, 8'h0e);
    pins <= 4'b0001;
    tick(2);
    rd(A_ST);
    chk(rdat[7:0], 8'h00);
    rd(A_FLG);
    chk(rdat[7:0], 8'h11);
    pins <= 4'b0101;
    tick(2);
    rd(A_ST);
    chk(rdat[7:0], 8'h80);
    rd(A_FLG);
    chk(rdat[7:0], 8'h45);
    rd(A_FLG);
    chk(rdat[7:0], 8'h05);
    rd(A_ST);
    chk(rdat[7:0], 8'h00);
    pins <= 4'b1101;
    rd(A_FLG);
    rd(A_FLG);
    chk(rdat[7:0], 8'h8d);
    rd(A_ST);
    chk({rdat[7:1], rerr}, 8'h00);
  endtask : t_pins
  // each level source in its own bit, unmasked on status_raw
  task t_layout();
    for (int i = 0; i < 4; i++) begin
      lv <= 4'h1 << i;
      tick(2);
      rd(A_ST);
      chk(rdat[7:0], {2'b00, lv[3:2], 2'b00, lv[1:0]});
      chk(status_raw, {2'b00, lv[3:2], 2'b00, lv[1:0]});
      chk({7'h00, irq_out_n}, 8'h01);
    end
    lv <= 4'h2;
    wr(A_ST, 8'hfd);
    tick(2);
    chk({7'h00, irq_out_n}, 8'h01);
    rd(A_ST);
    chk(rdat[7:0], 8'h02);
    wr(A_ST, 8'h02);
    tick(2);
    chk({7'h00, irq_out_n}, 8'h00);
    lv <= 4'h0;
    tick(3);
    chk({7'h00, irq_out_n}, 8'h01);
  endtask : t_layout
  // break flags stay until their own reset command
  task t_break();
    for (int c = 0; c < 2; c++) begin
      brk <= 2'b01 << c;
      tick(1);
      brk <= 2'b00;
      tick(4);
      rd(A_ST);
      chk(rdat[7:0], c ? 8'h40 : 8'h04);
      wr(A_CMD, c ? 8'h01 : 8'h02);
      rd(A_ST);
      chk(rdat[7:0], c ? 8'h40 : 8'h04);
      wr(A_CMD, c ? 8'h02 : 8'h01);
      rd(A_ST);
      chk(rdat[7:0], 8'h00);
    end
  endtask : t_break
  // counter mode and timer mode ready bit
  task t_ct();
    for (int m = 0; m < 2; m++) begin
      wr(A_FLG, m ? 8'h40 : 8'h00);
      rd(A_GO);
      for (int k = 0; k < 2; k++) begin
        ct_zero <= 1'b1;
        tick(1);
        ct_zero <= 1'b0;
        tick(2);
        rd(A_ST);
        chk(rdat[7:0], (m && k == 0) ? 8'h00 : 8'h08);
      end
      rd(A_STOP);
      rd(A_ST);
      chk(rdat[7:0], 8'h00);
    end
    rd(8'h20);
    chk({rdat[7:1], rerr}, 8'h01);
  endtask : t_ct
  // status clears on reset, also in mid-run
  task t_reset();
    wr(A_ST, 8'h04);
    brk <= 2'b01;
    tick(1);
    brk <= 2'b00;
    tick(2);
    chk({7'h00, irq_out_n}, 8'h00);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    rd(A_ST);
    chk(rdat[7:0], 8'h00);
    chk({7'h00, irq_out_n}, 8'h01);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    pins = 4'h0;
    lv = 4'h0;
    brk = 2'b00;
    ct_zero = 1'b0;
    err_count = 0;
    compares = 0;
    tick(12);
    rst_n <= 1'b1;
    tick(2);
    rd(A_ST);
    chk(rdat[7:0], 8'h00);
    t_pins();
    t_layout();
    t_break();
    t_ct();
    t_reset();
    end_sim();
  end
endmodule : uim_irq_top_test
